//--- sut_partner.sv
// Serial line peer: decodes transmitted frames and sends frames to the receiver.
// Assumes the bench sets the bit time in hclk cycles; the receive line idles high.
module sut_partner (
  input wire logic hclk, // Clock.
  input wire logic txd_out, // Line from the transmitter.
  input wire logic txd_oe, // Transmitter owns the line.
  input wire logic [7:0] bit_clks, // Cycles per bit.
  input wire logic [3:0] nb, // Data bits per frame.
  input wire logic pen, // Parity bit present.
  input wire logic go, // Start sending.
  input wire logic [23:0] bits, // Bits to send, first in bit 0.
  input wire logic [4:0] len, // Number of bits to send.
  output logic rxd_in, // Line to the receiver.
  output logic got, // Frame decoded, one cycle.
  output logic [10:0] word // Stop, parity, data.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev;
  logic [10:0] w;

  // Samples each bit in its middle, starting from the falling start edge.
  initial begin
    got = 1'b0;
    word = '0;
    prev = 1'b1;
    forever begin
      @(posedge hclk);
      got <= 1'b0;
      if (txd_oe && prev && !txd_out) begin
        w = '0;
        repeat (bit_clks / 2) @(posedge hclk);
        for (int i = 0; i < nb + pen + 1; i++) begin
          repeat (bit_clks) @(posedge hclk);
          if (i < nb) w[i] = txd_out;
          else if (pen && i == nb) w[9] = txd_out;
          else w[10] = txd_out;
        end
        word <= w;
        got <= 1'b1;
      end
      prev = txd_out;
    end
  end

  initial begin
    rxd_in = 1'b1;
    forever begin
      @(posedge hclk);
      if (go) begin
        for (int i = 0; i < len; i++) begin
          rxd_in <= bits[i];
          repeat (bit_clks) @(posedge hclk);
        end
        rxd_in <= 1'b1;
      end
    end
  end
endmodule : sut_partner

//--- sut_pkg.sv
// Constants and types shared by the serial transmit/receive path.
// Assumes a byte-addressed AHB-Lite slave window with one register per word.
package sut_pkg;
  localparam logic [7:0] OFF_STATUS_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_FRAME_C = 8'h08;
  localparam logic [7:0] OFF_BAUD_HI = 8'h0C;
  localparam logic [7:0] OFF_BAUD_LO = 8'h10;
  localparam logic [7:0] OFF_DATA = 8'h14;
  // Bits of serial_status_ctrl_a.
  localparam int BIT_RX_DONE = 7;
  localparam int BIT_TX_DONE = 6;
  localparam int BIT_BUF_EMPTY = 5;
  localparam int BIT_DOUBLE_SPEED = 1;
  // Bits of serial_ctrl_b.
  localparam int BIT_TXC_IE = 6;
  localparam int BIT_BE_IE = 5;
  localparam int BIT_RX_EN = 4;
  localparam int BIT_TX_EN = 3;
  localparam int BIT_SIZE_HI = 2;
  localparam int BIT_RX_NINTH = 1;
  localparam int BIT_TX_NINTH = 0;
  // Bits of serial_frame_ctrl_c.
  localparam int BIT_SYNC_MASTER = 7;
  localparam int BIT_SYNC_MODE = 6;
  localparam int BIT_PAR_EN = 5;
  localparam int BIT_PAR_ODD = 4;
  localparam int BIT_STOP2 = 3;
  localparam int BIT_SIZE_LO = 1;
  localparam int BIT_CLK_POL = 0;
  localparam logic [7:0] FRAME_C_RESET = 8'h06;
  localparam logic [4:0] OS_NORMAL = 5'h10;
  localparam logic [4:0] OS_DOUBLE = 5'h08;
  localparam logic [2:0] SIZE_NINE = 3'h7;
  localparam logic [3:0] DATA_MIN = 4'h5;
  localparam logic [3:0] DATA_NINE = 4'h9;
  localparam int BAUD_W = 12;
  localparam int FRAME_W = 13;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} sut_rx_state_t;

  typedef struct packed {
    logic hreadyout;
    logic [31:0] hrdata;
    logic rd_pend;
    logic [7:0] rd_addr;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic double_speed;
    logic txc_ie;
    logic be_ie;
    logic rx_en;
    logic tx_en;
    logic size_hi;
    logic tx_ninth;
    logic [7:0] frame_c;
    logic [BAUD_W-1:0] baud_div;
    logic [BAUD_W-1:0] baud_cnt;
    logic xck_out;
    logic xck_prev;
    logic [8:0] tx_buf;
    logic tx_full;
    logic tx_done;
    logic tx_busy;
    logic [FRAME_W-1:0] tx_shift;
    logic [3:0] tx_left;
    logic [4:0] tx_os;
    logic txd;
    logic txd_oe;
    logic xck_oe;
    logic rxd_owned;
    sut_rx_state_t rx_state;
    logic [4:0] rx_os;
    logic [3:0] rx_idx;
    logic [10:0] rx_shift;
    logic [8:0] rx_buf;
    logic rx_full;
    logic irq_be;
    logic irq_tc;
  } sut_state_t;
endpackage : sut_pkg

//--- sut_top.sv
// Serial transmit path and receive front end with an AHB-Lite register slave.
// Assumes pins are synchronous to hclk and one AHB-Lite master drives the slave.
// Function
// [RL1] Transmit enable takes over the data pin.
// [RL2] Synchronous mode transmits on external clock.
// [RL3] Buffer loads shifter when idle or after stop.
// [RL4] Shifter sends whole frame at mode rate.
// [RL5] Upper written bits ignored below eight bits.
// [RL6] Host sets ninth bit before low byte.
// [RL7] Buffer-empty flag mirrors buffer holding nothing.
// [RL8] Data write clears buffer-empty flag.
// [RL9] Buffer-empty request persists while flag set.
// [RL10] Handler writes data or disables request.
// [RL11] Complete flag sets when frame and buffer drained.
// [RL12] Complete flag clears on service or write-one.
// [RL13] Complete request follows flag when enabled.
// [RL14] Host writes zero to buffer-empty position.
// [RL15] Parity bit inserted after data bits.
// [RL16] Transmit disable waits until fully drained.
// [RL17] Receive enable takes over the receive pin.
// [RL18] Synchronous receive clocks on external clock.
// [RL19] Receiver starts on valid start, shifts bits.
// [RL20] Second stop bit never checked.
// [RL21] First stop moves frame into buffer.
// [RL22] Unused upper received bits read zero.
// [RL23] Frame: start, data LSB first, parity, stops.
// [RL24] Parity is XOR of data, inverted odd.
// [RL25] Receive flag shows unread buffered data.
// [RL26] Clock polarity picks change and sample edges.
// [RL27] Enabled idle transmitter holds line high.
//
// Added by the designer: the AHB-Lite slave port and the register offsets.
module sut_top (
  input wire logic hclk, // System clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size, word only.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  output logic hreadyout, // Slave ready.
  output logic [31:0] hrdata, // Read data.
  output logic hresp, // Always OKAY.
  output logic txd_out, // Serial transmit data.
  output logic txd_oe, // Transmitter owns the data pin.
  input wire logic rxd_in, // Serial receive data.
  output logic rxd_owned, // Receiver owns the receive pin.
  input wire logic xck_in, // External bit clock in.
  output logic xck_out, // External bit clock out.
  output logic xck_oe, // Clock pin driven as master.
  input wire logic global_irq_en, // Global interrupt enable.
  input wire logic tc_irq_taken, // Complete interrupt serviced.
  output logic irq_buf_empty, // Buffer-empty request.
  output logic irq_tx_complete // Transmit-complete request.
);
  sut_pkg::sut_state_t st;
  sut_pkg::sut_state_t nx;

  function automatic logic [3:0] data_bits(input logic [2:0] code);
    data_bits = (code == sut_pkg::SIZE_NINE) ? sut_pkg::DATA_NINE
              : 4'(sut_pkg::DATA_MIN + {2'h0, code[1:0]});
  endfunction : data_bits

  function automatic logic [8:0] mask_data(input logic [8:0] d, input logic [3:0] nb);
    logic [8:0] m;
    m = 9'h000;
    for (int i = 0; i < 9; i++) begin
      m[i] = d[i] & (i < int'(nb));
    end
    mask_data = m;
  endfunction : mask_data

  function automatic logic [sut_pkg::FRAME_W-1:0] build_frame(input logic [8:0] d,
      input logic [3:0] nb, input logic pe, input logic po);
    logic [sut_pkg::FRAME_W-1:0] f;
    logic [8:0] md;
    md = mask_data(d, nb);
    f = '1;
    f[0] = 1'h0;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(nb)) begin
        f[i + 1] = md[i];
      end
    end
    if (pe) begin
      f[4'(nb + 4'h1)] = ^md ^ po; // RL15 RL24
    end
    build_frame = f;
  endfunction : build_frame

  logic baud_tick;
  logic sync;
  logic master;
  logic pol;
  logic xck_lvl;
  logic xck_rise;
  logic xck_fall;
  logic chg_edge;
  logic smp_edge;
  logic [4:0] os_len;
  logic [2:0] size_code;
  logic [3:0] nbits;
  logic pe;
  logic tx_strobe;
  logic tx_load;
  logic tc_set;
  logic tc_clr;
  logic data_wr;
  logic data_rd;
  logic rx_smp;
  logic [10:0] rx_tmp;
  logic [3:0] rx_len;
  logic [7:0] w;
  logic [7:0] rd_val;

  always_comb begin
    nx = st;
    tx_load = 1'h0;
    tc_set = 1'h0;
    tc_clr = 1'h0;
    data_wr = 1'h0;
    data_rd = 1'h0;
    rx_smp = 1'h0;
    rx_tmp = st.rx_shift;
    rd_val = 8'h00;
    w = hwdata[7:0];
    sync = st.frame_c[sut_pkg::BIT_SYNC_MODE];
    master = st.frame_c[sut_pkg::BIT_SYNC_MASTER];
    pol = st.frame_c[sut_pkg::BIT_CLK_POL];
    size_code = {st.size_hi, st.frame_c[sut_pkg::BIT_SIZE_LO +: 2]};
    nbits = data_bits(size_code);
    pe = st.frame_c[sut_pkg::BIT_PAR_EN];
    os_len = st.double_speed ? sut_pkg::OS_DOUBLE : sut_pkg::OS_NORMAL; // RL4
    rx_len = 4'(nbits + {3'h0, pe} + 4'h1); // RL20

    // Baud divider and internal clock for synchronous master mode.
    baud_tick = (st.baud_cnt == '0);
    nx.baud_cnt = baud_tick ? st.baud_div : st.baud_cnt - 12'h001;
    if (sync && master) begin
      if (baud_tick) begin
        nx.xck_out = ~st.xck_out;
      end
    end else begin
      nx.xck_out = 1'h0;
    end
    xck_lvl = master ? st.xck_out : xck_in; // RL2 RL18
    nx.xck_prev = xck_lvl;
    xck_rise = xck_lvl & ~st.xck_prev;
    xck_fall = ~xck_lvl & st.xck_prev;
    chg_edge = pol ? xck_fall : xck_rise; // RL26
    smp_edge = pol ? xck_rise : xck_fall; // RL26

    // Bus slave: address phase, then write commit or one wait state for a read.
    nx.wr_pend = 1'h0;
    if (hsel && htrans[1] && hready) begin
      if (hwrite) begin
        nx.wr_pend = 1'h1;
        nx.wr_addr = haddr[7:0];
      end else begin
        nx.rd_pend = 1'h1;
        nx.rd_addr = haddr[7:0];
        nx.hreadyout = 1'h0;
      end
    end
    if (st.rd_pend) begin
      case (st.rd_addr)
        sut_pkg::OFF_STATUS_A: begin
          rd_val[sut_pkg::BIT_RX_DONE] = st.rx_full; // RL25
          rd_val[sut_pkg::BIT_TX_DONE] = st.tx_done;
          rd_val[sut_pkg::BIT_BUF_EMPTY] = ~st.tx_full; // RL7
          rd_val[sut_pkg::BIT_DOUBLE_SPEED] = st.double_speed;
        end
        sut_pkg::OFF_CTRL_B: begin
          rd_val[sut_pkg::BIT_TXC_IE] = st.txc_ie;
          rd_val[sut_pkg::BIT_BE_IE] = st.be_ie;
          rd_val[sut_pkg::BIT_RX_EN] = st.rx_en;
          rd_val[sut_pkg::BIT_TX_EN] = st.tx_en;
          rd_val[sut_pkg::BIT_SIZE_HI] = st.size_hi;
          rd_val[sut_pkg::BIT_RX_NINTH] = st.rx_buf[8];
          rd_val[sut_pkg::BIT_TX_NINTH] = st.tx_ninth;
        end
        sut_pkg::OFF_FRAME_C: rd_val = st.frame_c;
        sut_pkg::OFF_BAUD_HI: rd_val = {4'h0, st.baud_div[11:8]};
        sut_pkg::OFF_BAUD_LO: rd_val = st.baud_div[7:0];
        sut_pkg::OFF_DATA: begin
          rd_val = st.rx_buf[7:0];
          data_rd = 1'h1;
        end
        default: rd_val = 8'h00;
      endcase
      nx.hrdata = {24'h00_0000, rd_val};
      nx.hreadyout = 1'h1;
      nx.rd_pend = 1'h0;
    end
    if (st.wr_pend) begin
      case (st.wr_addr)
        sut_pkg::OFF_STATUS_A: begin
          nx.double_speed = w[sut_pkg::BIT_DOUBLE_SPEED];
          tc_clr = w[sut_pkg::BIT_TX_DONE]; // RL12
        end
        sut_pkg::OFF_CTRL_B: begin
          nx.txc_ie = w[sut_pkg::BIT_TXC_IE];
          nx.be_ie = w[sut_pkg::BIT_BE_IE];
          nx.rx_en = w[sut_pkg::BIT_RX_EN];
          nx.tx_en = w[sut_pkg::BIT_TX_EN];
          nx.size_hi = w[sut_pkg::BIT_SIZE_HI];
          nx.tx_ninth = w[sut_pkg::BIT_TX_NINTH];
        end
        sut_pkg::OFF_FRAME_C: nx.frame_c = w;
        sut_pkg::OFF_BAUD_HI: nx.baud_div[11:8] = w[3:0];
        sut_pkg::OFF_BAUD_LO: nx.baud_div[7:0] = w;
        sut_pkg::OFF_DATA: data_wr = 1'h1;
        default: nx.frame_c = st.frame_c;
      endcase
    end

    // Transmitter: one-deep buffer feeding the frame shifter.
    if (sync) begin
      tx_strobe = chg_edge; // RL2
    end else begin
      tx_strobe = baud_tick && (st.tx_os == 5'(os_len - 5'h01)); // RL4
      if (st.tx_busy && baud_tick) begin
        nx.tx_os = tx_strobe ? 5'h00 : 5'(st.tx_os + 5'h01);
      end
    end
    if (st.tx_busy && tx_strobe) begin
      if (st.tx_left == 4'h1) begin
        if (st.tx_full) begin
          tx_load = 1'h1; // RL3
        end else begin
          nx.tx_busy = 1'h0;
          tc_set = 1'h1; // RL11
        end
      end else begin
        nx.tx_shift = {1'h1, st.tx_shift[sut_pkg::FRAME_W-1:1]}; // RL23
        nx.tx_left = 4'(st.tx_left - 4'h1);
      end
    end
    if (!st.tx_busy && st.tx_full && (!sync || tx_strobe)) begin
      tx_load = 1'h1; // RL3 RL16
    end
    if (tx_load) begin
      nx.tx_shift = build_frame(st.tx_buf, nbits, pe, st.frame_c[sut_pkg::BIT_PAR_ODD]); // RL5
      nx.tx_left = 4'(nbits + {3'h0, pe} + 4'h2 + {3'h0, st.frame_c[sut_pkg::BIT_STOP2]});
      nx.tx_busy = 1'h1;
      nx.tx_os = 5'h00;
      nx.tx_full = 1'h0; // RL7
    end
    if (data_wr) begin
      nx.tx_buf = {st.tx_ninth, w}; // RL6
      nx.tx_full = 1'h1; // RL8
    end
    if (tc_irq_taken) begin
      tc_clr = 1'h1; // RL12
    end
    if (tc_clr) begin
      nx.tx_done = 1'h0;
    end
    if (tc_set) begin
      nx.tx_done = 1'h1;
    end
    nx.txd = nx.tx_busy ? nx.tx_shift[0] : 1'h1; // RL27
    nx.txd_oe = nx.tx_en | nx.tx_busy | nx.tx_full; // RL1 RL16
    nx.xck_oe = &nx.frame_c[sut_pkg::BIT_SYNC_MODE +: 2] & (nx.txd_oe | nx.rx_en); // RL2
    nx.rxd_owned = nx.rx_en; // RL17

    // Receiver front end.
    if (data_rd) begin
      nx.rx_full = 1'h0;
    end
    if (!st.rx_en) begin
      nx.rx_state = sut_pkg::RX_IDLE;
      nx.rx_full = 1'h0; // RL25
    end else begin
      case (st.rx_state)
        sut_pkg::RX_IDLE: begin
          nx.rx_idx = 4'h0;
          nx.rx_os = 5'h00;
          if (sync) begin
            if (smp_edge && !rxd_in) begin
              nx.rx_state = sut_pkg::RX_BITS; // RL18 RL19
            end
          end else if (baud_tick && !rxd_in) begin
            nx.rx_state = sut_pkg::RX_START;
          end
        end
        sut_pkg::RX_START: begin
          if (baud_tick) begin
            nx.rx_os = 5'(st.rx_os + 5'h01);
            if (st.rx_os == 5'((os_len >> 1) - 5'h01)) begin
              nx.rx_os = 5'h00;
              nx.rx_state = rxd_in ? sut_pkg::RX_IDLE : sut_pkg::RX_BITS; // RL19
            end
          end
        end
        sut_pkg::RX_BITS: begin
          if (sync) begin
            rx_smp = smp_edge;
          end else if (baud_tick) begin
            rx_smp = (st.rx_os == 5'(os_len - 5'h01));
            nx.rx_os = rx_smp ? 5'h00 : 5'(st.rx_os + 5'h01);
          end
          if (rx_smp) begin
            rx_tmp[st.rx_idx] = rxd_in; // RL19
            nx.rx_shift = rx_tmp;
            nx.rx_idx = 4'(st.rx_idx + 4'h1);
            if (st.rx_idx == 4'(rx_len - 4'h1)) begin
              nx.rx_buf = mask_data(rx_tmp[8:0], nbits); // RL21 RL22
              nx.rx_full = 1'h1; // RL21
              nx.rx_state = sut_pkg::RX_IDLE; // RL20
            end
          end
        end
        default: nx.rx_state = sut_pkg::RX_IDLE;
      endcase
    end

    nx.irq_be = global_irq_en & nx.be_ie & ~nx.tx_full; // RL9
    nx.irq_tc = global_irq_en & nx.txc_ie & nx.tx_done; // RL13
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      st.hreadyout <= 1'h1;
      st.frame_c <= sut_pkg::FRAME_C_RESET;
      st.txd <= 1'h1;
      st.rx_state <= sut_pkg::RX_IDLE;
    end else begin
      st <= nx;
    end
  end

  assign hreadyout = st.hreadyout;
  assign hrdata = st.hrdata;
  assign hresp = 1'h0;
  assign txd_out = st.txd;
  assign txd_oe = st.txd_oe;
  assign rxd_owned = st.rxd_owned;
  assign xck_out = st.xck_out;
  assign xck_oe = st.xck_oe;
  assign irq_buf_empty = st.irq_be;
  assign irq_tx_complete = st.irq_tc;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  buf_full_write_a: assert property ( // RL8
    (st.wr_pend && st.wr_addr == sut_pkg::OFF_DATA) |=> st.tx_full || st.tx_busy)
    else $error("data write did not fill the transmit buffer");
  idle_line_high_a: assert property (!st.tx_busy |-> txd_out) // RL27
    else $error("idle transmit line not high");
  start_bit_low_a: assert property ($rose(st.tx_busy) |-> !txd_out) // RL23
    else $error("frame did not open with a low start bit");
  drain_keeps_pin_a: assert property (st.tx_busy || st.tx_full |-> txd_oe) // RL16
    else $error("pin released before transmitter drained");
  done_after_frame_a: assert property ($fell(st.tx_busy) |-> st.tx_done) // RL11
    else $error("complete flag not set after last frame");
  rx_flush_off_a: assert property (!st.rx_en |=> !st.rx_full) // RL25
    else $error("receive buffer not flushed when disabled");
  be_request_a: assert property ( // RL9
    irq_buf_empty == ($past(global_irq_en) && st.be_ie && !st.tx_full))
    else $error("buffer-empty request does not follow its flag");
  clk_pin_master_a: assert property (xck_oe |-> sync && master) // RL2
    else $error("clock pin driven outside master mode");
  rx_upper_zero_a: assert property ( // RL22
    $rose(st.rx_full) && size_code != sut_pkg::SIZE_NINE |-> !st.rx_buf[8])
    else $error("unused received bit not zero");
endmodule : sut_top

//--- tb.sv
// Self-checking bench for the serial path: register bus, transmit and receive frames.
// Assumes one bus master, the peer model on the serial lines and no external clock.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, txd_out, txd_oe, rxd_in, rxd_owned;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, sz;
  logic gie, tc_taken, irq_be, irq_tc, pen, go, got, pe, od, ds, pol, xck_o, xck_e, last_txd;
  logic [7:0] bit_clks, div;
  logic [3:0] nb;
  logic [23:0] bits;
  logic [4:0] len;
  logic [10:0] word;
  logic [10:0] exp_q[$];
  logic [8:0] d, m;
  logic [8:0] md[2];
  int n, pos;
  int error_cnt = 0;
  int n_compared = 0;

  sut_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .txd_out(txd_out),
    .txd_oe(txd_oe), .rxd_in(rxd_in), .rxd_owned(rxd_owned), .xck_in(1'b0), .xck_out(xck_o),
    .xck_oe(xck_e), .global_irq_en(gie), .tc_irq_taken(tc_taken), .irq_buf_empty(irq_be),
    .irq_tx_complete(irq_tc));
  sut_partner peer (.hclk(hclk), .txd_out(txd_out), .txd_oe(txd_oe), .bit_clks(bit_clks),
    .nb(nb), .pen(pen), .go(go), .bits(bits), .len(len), .rxd_in(rxd_in), .got(got),
    .word(word));

  task automatic test_done;
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic bad_wait;
    error_cnt++;
    $display("BAD %0t wait ran out", $time);
    test_done();
  endtask : bad_wait

  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) bad_wait();
  endtask : wait_rdy

  // One single word transfer; read data lands in rd.
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= 32'(a);
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= dat;
    wait_rdy();
    rd = hrdata;
  endtask : ahb

  task automatic poll(input int b);
    int k;
    k = 0;
    do begin
      ahb(1'b0, sut_pkg::OFF_STATUS_A, 0);
      k++;
    end while (rd[b] !== 1'b1 && k < 2000);
    if (rd[b] !== 1'b1) bad_wait();
  endtask : poll

  always @(posedge hclk) begin
    if (got === 1'b1) chk(32'(word), exp_q.size() ? 32'(exp_q.pop_front()) : '1);
  end

  // In synchronous master mode the line may change only on the change edge of the clock.
  always @(posedge hclk) begin
    if (xck_e === 1'b1 && txd_out !== last_txd) chk(32'(xck_o), 32'(!pol));
    last_txd <= txd_out;
  end

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  initial begin
    repeat (90000) @(posedge hclk);
    bad_wait();
  end

  initial begin
    {hresetn, hsel, hwrite, gie, tc_taken, go, pen, pol} = '0;
    {haddr, hwdata, bits, len, htrans} = '0;
    hsize = 3'h2;
    nb = 4'h8;
    bit_clks = 8'h10;
    void'($urandom(83685));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, sut_pkg::OFF_STATUS_A, 0);
    chk(rd, 32'h0000_0020);
    ahb(1'b0, sut_pkg::OFF_FRAME_C, 0);
    chk(rd, 32'(sut_pkg::FRAME_C_RESET));
    ahb(1'b0, 8'h18, 0);
    chk(rd, 0);
    ahb(1'b1, sut_pkg::OFF_CTRL_B, 32'h0000_0078);
    gie <= 1'b1;
    repeat (3) @(posedge hclk);
    chk(32'({hresp, txd_oe, rxd_owned, txd_out, irq_be}), 32'h0000_000F);
    // Size codes 0 to 3 and 7 and every parity mode, two characters back to back each.
    for (int i = 0; i < 5; i++) begin
      sz = (i == 4) ? 3'h7 : 3'(i);
      n = (i == 4) ? 9 : i + 5;
      pe = (i % 3) != 0;
      od = (i % 3) == 2;
      ds = i == 3;
      div = 8'($urandom_range(2));
      bit_clks <= (ds ? 8'h08 : 8'h10) * (div + 8'h01);
      nb <= 4'(n);
      pen <= pe;
      ahb(1'b1, sut_pkg::OFF_BAUD_LO, 32'(div));
      ahb(1'b1, sut_pkg::OFF_STATUS_A, 32'(ds) << 1);
      ahb(1'b1, sut_pkg::OFF_FRAME_C, 32'({pe, od, 1'b0, sz[1:0], 1'b0}));
      for (int k = 0; k < 2; k++) begin
        d = 9'($urandom);
        m = d & 9'((1 << n) - 1);
        exp_q.push_back({1'b1, pe & (^m ^ od), m});
        ahb(1'b1, sut_pkg::OFF_CTRL_B, 32'h0000_0078 | 32'({sz[2], 1'b0, d[8]}));
        ahb(1'b1, sut_pkg::OFF_DATA, 32'(d[7:0]));
      end
      ahb(1'b0, sut_pkg::OFF_STATUS_A, 0);
      chk(rd | (32'(irq_be) << 8), 32'(ds) << 1);
      poll(sut_pkg::BIT_TX_DONE);
      chk(32'({irq_tc, irq_be}), 32'h0000_0003);
      if (i % 2 == 1) ahb(1'b1, sut_pkg::OFF_STATUS_A, 32'h0000_0040 | (32'(ds) << 1));
      else begin
        tc_taken <= 1'b1;
        @(posedge hclk);
        tc_taken <= 1'b0;
      end
      ahb(1'b0, sut_pkg::OFF_STATUS_A, 0);
      chk(rd, 32'h0000_0020 | (32'(ds) << 1));
    end
    // Transmitter switched off while a character is still going out.
    ahb(1'b1, sut_pkg::OFF_FRAME_C, 32'h0000_0006);
    nb <= 4'h8;
    pen <= 1'b0;
    exp_q.push_back(11'h4A5);
    // Back to eight-bit characters: the last loop pass left the ninth-bit size code set.
    ahb(1'b1, sut_pkg::OFF_CTRL_B, 32'h0000_0008);
    ahb(1'b1, sut_pkg::OFF_DATA, 32'h0000_00A5);
    ahb(1'b1, sut_pkg::OFF_CTRL_B, 32'h0000_0010);
    repeat (40) @(posedge hclk);
    chk(32'(txd_oe), 1);
    poll(sut_pkg::BIT_TX_DONE);
    chk(32'(txd_oe), 0);
    // Three settings, two received frames each, with one stop bit each while two are configured.
    for (int j = 0; j < 3; j++) begin
      sz = (j == 2) ? 3'h7 : ((j == 0) ? 3'h3 : 3'h0);
      n = (j == 2) ? 9 : 32'(sz) + 5;
      pe = j == 1;
      ahb(1'b1, sut_pkg::OFF_FRAME_C, 32'({pe, 1'b0, 1'b1, sz[1:0], 1'b0}));
      ahb(1'b1, sut_pkg::OFF_CTRL_B, 32'h0000_0010 | (32'(sz[2]) << 2));
      pos = 0;
      bits = '0;
      for (int k = 0; k < 2; k++) begin
        md[k] = 9'($urandom) & 9'((1 << n) - 1);
        for (int b = 0; b < n; b++) bits[pos + 1 + b] = md[k][b];
        pos = pos + n + 1;
        if (pe) bits[pos++] = ^md[k];
        bits[pos++] = 1'b1;
      end
      len <= 5'(pos);
      go <= 1'b1;
      @(posedge hclk);
      go <= 1'b0;
      for (int k = 0; k < 2; k++) begin
        poll(sut_pkg::BIT_RX_DONE);
        ahb(1'b0, sut_pkg::OFF_CTRL_B, 0);
        if (sz == 3'h7) chk(32'(rd[1]), 32'(md[k][8]));
        ahb(1'b0, sut_pkg::OFF_DATA, 0);
        chk(rd, 32'(md[k][7:0]));
        ahb(1'b0, sut_pkg::OFF_STATUS_A, 0);
        chk(32'(rd[7]), 0);
      end
    end
    // Synchronous master transmit at both clock polarities, bit time of eight clocks.
    ahb(1'b1, sut_pkg::OFF_CTRL_B, 32'h0000_0008);
    ahb(1'b1, sut_pkg::OFF_BAUD_LO, 32'h0000_0003);
    bit_clks <= 8'h08;
    for (int p = 0; p < 2; p++) begin
      pol = 1'(p);
      ahb(1'b1, sut_pkg::OFF_FRAME_C, 32'h0000_00C6 | 32'(p));
      ahb(1'b1, sut_pkg::OFF_STATUS_A, 32'h0000_0040);
      d = 9'($urandom) & 9'h0FF;
      exp_q.push_back({2'b10, d});
      ahb(1'b1, sut_pkg::OFF_DATA, 32'(d));
      chk(32'(xck_e), 1);
      poll(sut_pkg::BIT_TX_DONE);
    end
    ahb(1'b1, sut_pkg::OFF_FRAME_C, 32'h0000_0006);
    ahb(1'b1, sut_pkg::OFF_CTRL_B, 32'h0000_0000);
    repeat (20) @(posedge hclk);
    chk(32'(exp_q.size()), 0);
    chk(32'(xck_e), 0);
    test_done();
  end
endmodule : tb
